// >>> common/wdt_pkg.sv
// Constants and types shared by the windowed watchdog
package wdt_pkg;
  // ---------------------------------------------------------------
  // Register port
  // ---------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam logic [3:0] RCR_ADDR = 4'h0;
  localparam logic [3:0] CNT_ADDR = 4'h1;
  localparam logic [3:0] CFG_ADDR = 4'h2;
  localparam logic [3:0] MODE_ADDR = 4'h3;
  localparam int RCR_IDLE_BIT = 2;
  localparam int RCR_SLEEP_BIT = 3;
  localparam int RCR_WATCHDOG_TIMEOUT_FLAG_BIT = 4;
  localparam int RCR_SWEN_BIT = 5;
  localparam logic [15:0] RDATA_RESET = 16'h0000;

  // ---------------------------------------------------------------
  // Configuration word fields
  // ---------------------------------------------------------------
  localparam int CFG_POST_LSB = 0;
  localparam int CFG_PRE_BIT = 4;
  localparam int CFG_WINSEL_LSB = 5;
  localparam int CFG_WINDOW_DISABLE_BIT_BIT = 7;
  localparam int CFG_EN_LSB = 14;
  localparam logic [15:0] CFG_RESET = 16'h0000;
  localparam logic [1:0] EN_SW_ONLY = 2'h0;

  // ---------------------------------------------------------------
  // Prescaler terminal counts (divide by 32 or by 128)
  // ---------------------------------------------------------------
  localparam logic [6:0] PRE_LAST_SHORT = 7'h1f;
  localparam logic [6:0] PRE_LAST_LONG = 7'h7f;
  localparam logic [6:0] PRE_RESET = 7'h00;
  localparam logic [15:0] POST_RESET = 16'h0000;

  typedef enum logic [2:0] {
    WDT_RUN = 3'h1,
    WDT_SLEEP = 3'h2,
    WDT_IDLE = 3'h4
  } wdt_mode_t;

  typedef struct packed {
    wdt_mode_t mode;
    logic [15:0] post_cnt;
    logic swen;
    logic watchdog_timeout_flag;
    logic sleep_f;
    logic idle_f;
    logic rst_req;
    logic wake;
    logic [15:0] cfg;
    logic [15:0] rdata;
  } wdt_core_t;
endpackage

// >>> src/wdt_edge_sync.sv
// Two-flop synchroniser with rising-edge detect for the RC clock pin
`timescale 1ns/1ps
module wdt_edge_sync (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic async_i,
  output logic rise_o
);
  typedef struct packed {
    logic meta;
    logic sync;
    logic last;
  } wdt_sync_t;

  wdt_sync_t cur_reg;
  wdt_sync_t cur_next;

  always_comb begin
    cur_next.meta = async_i;
    cur_next.sync = cur_reg.meta;
    cur_next.last = cur_reg.sync;
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cur_reg <= '0;
    end else begin
      cur_reg <= cur_next;
    end
  end

  // Edge taken from the second and third stage only
  assign rise_o = cur_reg.sync & ~cur_reg.last;
endmodule

// >>> src/wdt_prescaler.sv
// Watchdog prescaler: divides RC clock edges by 32 or 128
`timescale 1ns/1ps
module wdt_prescaler #(
  parameter int CNT_W = 7
) (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic edge_i,
  input wire logic run_i,
  input wire logic clr_i,
  input wire logic long_i,
  output logic tick_o
);
  typedef struct packed {
    logic [CNT_W-1:0] cnt;
  } wdt_pre_t;

  wdt_pre_t cur_reg;
  wdt_pre_t cur_next;
  logic [CNT_W-1:0] last;

  assign last = long_i ? CNT_W'(wdt_pkg::PRE_LAST_LONG) : CNT_W'(wdt_pkg::PRE_LAST_SHORT);
  // Tick is not gated by clear, which would loop back through the timeout
  assign tick_o = run_i & edge_i & (cur_reg.cnt == last);

  always_comb begin
    cur_next = cur_reg;
    if (clr_i || !run_i) begin
      cur_next.cnt = CNT_W'(wdt_pkg::PRE_RESET);
    end else if (edge_i) begin
      cur_next.cnt = (cur_reg.cnt == last) ? CNT_W'(0) : cur_reg.cnt + CNT_W'(1);
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cur_reg <= '0;
    end else begin
      cur_reg <= cur_next;
    end
  end

  a_pre_clear: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    clr_i |=> cur_reg.cnt == '0) else $error("prescaler not cleared");
  a_pre_wrap: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    tick_o && !clr_i |=> cur_reg.cnt == '0) else $error("prescaler did not wrap on tick");
endmodule

// >>> src/wdt_windowed_watchdog.sv
// Windowed watchdog timer with reset-control register and sleep wake
`timescale 1ns/1ps
module wdt_windowed_watchdog (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic [3:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rdata_o,
  input wire logic [15:0] watchdog_config_word_i,
  input wire logic low_power_rc_clock_i,
  input wire logic watchdog_clear_instruction_i,
  input wire logic power_save_instruction_i,
  input wire logic power_save_idle_i,
  input wire logic wake_event_i,
  input wire logic clock_switch_done_i,
  input wire logic device_reset_i,
  output logic low_power_rc_clock_enable_o,
  output logic wdt_reset_o,
  output logic wdt_wake_o
);
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [15:0] period_last(input logic [3:0] post);
    period_last = (16'h0001 << post) - 16'h0001;
  endfunction

  // Count at which clearing becomes legal; larger codes open earlier
  function automatic logic [15:0] win_open(input logic [3:0] post, input logic [1:0] sel);
    logic [15:0] p;
    p = 16'h0001 << post;
    case (sel)
      2'h0: win_open = p - (p >> 2);
      2'h1: win_open = p - (p >> 2) - (p >> 3);
      2'h2: win_open = p >> 1;
      2'h3: win_open = p >> 2;
      default: win_open = 16'h0000;
    endcase
  endfunction

  wdt_pkg::wdt_core_t cur_reg;
  wdt_pkg::wdt_core_t cur_next;

  logic rc_rise;
  logic tick;
  logic [3:0] post_sel;
  logic [1:0] win_sel;
  logic force_en;
  logic wdt_en;
  logic in_run;
  logic window_on;
  logic timeout;
  logic clr_run;
  logic viol;
  logic run_to;
  logic self_rst;
  logic any_rst;
  logic enter_ps;
  logic leave_ps;
  logic cnt_clr;
  logic rcr_wr;

  // ---------------------------------------------------------------
  // Clock input and prescaler
  // ---------------------------------------------------------------
  wdt_edge_sync u_sync (
    .mclk_i(mclk_i),
    .rstn_i(rstn_i),
    .async_i(low_power_rc_clock_i),
    .rise_o(rc_rise)
  );

  wdt_prescaler #(
    .CNT_W(7)
  ) u_pre (
    .mclk_i(mclk_i),
    .rstn_i(rstn_i),
    .edge_i(rc_rise),
    .run_i(wdt_en),
    .clr_i(cnt_clr),
    .long_i(cur_reg.cfg[wdt_pkg::CFG_PRE_BIT]),
    .tick_o(tick)
  );

  // ---------------------------------------------------------------
  // Event decode
  // ---------------------------------------------------------------
  assign post_sel = cur_reg.cfg[wdt_pkg::CFG_POST_LSB +: 4];
  assign win_sel = cur_reg.cfg[wdt_pkg::CFG_WINSEL_LSB +: 2];
  assign force_en = cur_reg.cfg[wdt_pkg::CFG_EN_LSB +: 2] != wdt_pkg::EN_SW_ONLY;
  assign wdt_en = force_en | cur_reg.swen;
  assign low_power_rc_clock_enable_o = wdt_en;
  assign in_run = cur_reg.mode == wdt_pkg::WDT_RUN;
  assign window_on = !cur_reg.cfg[wdt_pkg::CFG_WINDOW_DISABLE_BIT_BIT];
  assign timeout = tick && (cur_reg.post_cnt == period_last(post_sel));
  assign clr_run = watchdog_clear_instruction_i && in_run;
  assign viol = clr_run && wdt_en && window_on && (cur_reg.post_cnt < win_open(post_sel, win_sel));
  assign run_to = timeout && in_run;
  assign self_rst = run_to | viol;
  assign any_rst = device_reset_i | self_rst;
  assign enter_ps = power_save_instruction_i && in_run && !any_rst;
  assign leave_ps = !in_run && !device_reset_i && (wake_event_i | timeout);
  assign cnt_clr = any_rst | clock_switch_done_i | enter_ps | leave_ps | clr_run;
  assign rcr_wr = wr_i && (addr_i == wdt_pkg::RCR_ADDR);

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    cur_next = cur_reg;
    cur_next.cfg = watchdog_config_word_i;
    cur_next.rst_req = self_rst;
    cur_next.wake = leave_ps && timeout;
    if (cnt_clr || !wdt_en) begin
      cur_next.post_cnt = wdt_pkg::POST_RESET;
    end else if (tick) begin
      cur_next.post_cnt = cur_reg.post_cnt + 16'h0001;
    end
    if (any_rst) begin
      cur_next.mode = wdt_pkg::WDT_RUN;
    end else begin
      case (cur_reg.mode)
        wdt_pkg::WDT_RUN: begin
          if (power_save_instruction_i) begin
            cur_next.mode = power_save_idle_i ? wdt_pkg::WDT_IDLE : wdt_pkg::WDT_SLEEP;
          end
        end
        wdt_pkg::WDT_SLEEP, wdt_pkg::WDT_IDLE: begin
          if (leave_ps) begin
            cur_next.mode = wdt_pkg::WDT_RUN;
          end
        end
        default: begin
          cur_next.mode = wdt_pkg::WDT_RUN;
        end
      endcase
    end
    if (any_rst) begin
      cur_next.swen = 1'b0;
    end else if (rcr_wr) begin
      cur_next.swen = wdata_i[wdt_pkg::RCR_SWEN_BIT];
    end
    // Hardware set wins over a software clear in the same cycle
    cur_next.watchdog_timeout_flag = (rcr_wr ? wdata_i[wdt_pkg::RCR_WATCHDOG_TIMEOUT_FLAG_BIT] : cur_reg.watchdog_timeout_flag) | timeout;
    cur_next.sleep_f = (rcr_wr ? wdata_i[wdt_pkg::RCR_SLEEP_BIT] : cur_reg.sleep_f)
                       | (enter_ps & !power_save_idle_i);
    cur_next.idle_f = (rcr_wr ? wdata_i[wdt_pkg::RCR_IDLE_BIT] : cur_reg.idle_f)
                      | (enter_ps & power_save_idle_i);
    cur_next.rdata = wdt_pkg::RDATA_RESET;
    if (rd_i) begin
      case (addr_i)
        wdt_pkg::RCR_ADDR: begin
          cur_next.rdata[wdt_pkg::RCR_SWEN_BIT] = cur_reg.swen;
          cur_next.rdata[wdt_pkg::RCR_WATCHDOG_TIMEOUT_FLAG_BIT] = cur_reg.watchdog_timeout_flag;
          cur_next.rdata[wdt_pkg::RCR_SLEEP_BIT] = cur_reg.sleep_f;
          cur_next.rdata[wdt_pkg::RCR_IDLE_BIT] = cur_reg.idle_f;
        end
        wdt_pkg::CNT_ADDR: begin
          cur_next.rdata = cur_reg.post_cnt;
        end
        wdt_pkg::CFG_ADDR: begin
          cur_next.rdata = cur_reg.cfg;
        end
        wdt_pkg::MODE_ADDR: begin
          cur_next.rdata = {13'h0000, cur_reg.mode};
        end
        default: begin
          cur_next.rdata = wdt_pkg::RDATA_RESET;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cur_reg.mode <= wdt_pkg::WDT_RUN;
      cur_reg.post_cnt <= wdt_pkg::POST_RESET;
      cur_reg.swen <= 1'b0;
      cur_reg.watchdog_timeout_flag <= 1'b0;
      cur_reg.sleep_f <= 1'b0;
      cur_reg.idle_f <= 1'b0;
      cur_reg.rst_req <= 1'b0;
      cur_reg.wake <= 1'b0;
      cur_reg.cfg <= wdt_pkg::CFG_RESET;
      cur_reg.rdata <= wdt_pkg::RDATA_RESET;
    end else begin
      cur_reg <= cur_next;
    end
  end

  assign rdata_o = cur_reg.rdata;
  assign wdt_reset_o = cur_reg.rst_req;
  assign wdt_wake_o = cur_reg.wake;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking @(posedge mclk_i);
  endclocking
  default disable iff (!rstn_i);

  sequence s_reset_pulse;
    wdt_reset_o ##1 !wdt_reset_o;
  endsequence

  sequence s_woken;
    wdt_wake_o && !wdt_reset_o && (cur_reg.mode == wdt_pkg::WDT_RUN);
  endsequence

  sequence s_count_clear;
    cur_reg.post_cnt == wdt_pkg::POST_RESET;
  endsequence

  // ---------------------------------------------------------------
  // Enable
  // ---------------------------------------------------------------
  a_forced_enable: assert property (
    force_en |-> low_power_rc_clock_enable_o && wdt_en) else $error("forced enable ignored");
  a_sw_only_off: assert property (
    !force_en && !cur_reg.swen |-> !low_power_rc_clock_enable_o) else $error("watchdog on without enable");
  a_disabled_hold: assert property (
    !wdt_en |=> s_count_clear) else $error("disabled watchdog still counting");
  a_swen_write: assert property (
    rcr_wr && !any_rst |=> cur_reg.swen == $past(wdata_i[wdt_pkg::RCR_SWEN_BIT])) else $error("enable write lost");

  // ---------------------------------------------------------------
  // Clearing and counting
  // ---------------------------------------------------------------
  a_switch_clear: assert property (
    clock_switch_done_i |=> cur_reg.post_cnt == 16'h0000) else $error("clock switch did not clear");
  a_dev_reset: assert property (
    device_reset_i |=> s_count_clear) else $error("device reset did not clear");
  a_enter_ps_clear: assert property (
    enter_ps |=> cur_reg.post_cnt == 16'h0000 && !in_run) else $error("power save entry wrong");
  a_leave_clear: assert property (
    leave_ps |=> s_count_clear) else $error("power save exit did not clear");
  // A clear landing on the timeout tick loses to the timeout
  a_clear_restart: assert property (
    clr_run && !viol && !timeout |=> cur_reg.post_cnt == 16'h0000 && !wdt_reset_o) else $error("clear did not restart");
  a_count_step: assert property (
    tick && !cnt_clr && wdt_en |=> cur_reg.post_cnt == $past(cur_reg.post_cnt) + 16'h0001) else $error("count step wrong");

  // ---------------------------------------------------------------
  // Power save
  // ---------------------------------------------------------------
  a_sleep_wake: assert property (
    timeout && !in_run && !device_reset_i |=> s_woken ##1 !wdt_wake_o) else $error("timeout in sleep not a wake");
  a_no_sleep_reset: assert property (
    !in_run && !device_reset_i |=> !wdt_reset_o) else $error("reset raised in power save");
  a_wake_only: assert property (
    !leave_ps |=> !wdt_wake_o) else $error("wake without leaving power save");
  a_ps_refused: assert property (
    power_save_instruction_i && !in_run && !device_reset_i && !leave_ps |=> $stable(cur_reg.mode))
    else $error("power save taken outside run");
  a_sleep_flag: assert property (
    enter_ps && !power_save_idle_i |=> cur_reg.sleep_f && cur_reg.mode == wdt_pkg::WDT_SLEEP)
    else $error("sleep entry wrong");
  a_idle_flag: assert property (
    enter_ps && power_save_idle_i |=> cur_reg.idle_f && cur_reg.mode == wdt_pkg::WDT_IDLE)
    else $error("idle entry wrong");

  // ---------------------------------------------------------------
  // Flags and resets
  // ---------------------------------------------------------------
  a_swen_cleared: assert property (
    any_rst |=> !cur_reg.swen) else $error("software enable survived reset");
  a_flag_sticky: assert property (
    cur_reg.watchdog_timeout_flag && !rcr_wr |=> cur_reg.watchdog_timeout_flag) else $error("timeout flag lost");
  a_timeout_flag: assert property (
    timeout |=> cur_reg.watchdog_timeout_flag) else $error("timeout flag not set");
  a_sleep_kept: assert property (
    cur_reg.sleep_f && !rcr_wr |=> cur_reg.sleep_f) else $error("sleep flag lost");
  a_idle_kept: assert property (
    cur_reg.idle_f && !rcr_wr |=> cur_reg.idle_f) else $error("idle flag lost");
  a_run_timeout: assert property (
    run_to |=> s_reset_pulse and cur_reg.watchdog_timeout_flag) else $error("run timeout gave no reset");
  a_no_run_wake: assert property (
    run_to |=> !wdt_wake_o) else $error("run timeout gave a wake");
  a_no_stray_reset: assert property (
    !self_rst |=> !wdt_reset_o) else $error("reset without cause");
  a_window_viol: assert property (
    viol |=> s_reset_pulse) else $error("early clear gave no reset");
  a_window_off: assert property (
    clr_run && !window_on && !run_to && !device_reset_i |=> !wdt_reset_o) else $error("reset with window off");
  a_read_once: assert property (
    !rd_i |=> rdata_o == 16'h0000) else $error("read data outside its cycle");
endmodule

// >>> test/tb.sv
// Self-checking testbench for the windowed watchdog
`timescale 1ns/1ps
module tb;
  localparam logic [15:0] TO = 16'h0001 << wdt_pkg::RCR_WATCHDOG_TIMEOUT_FLAG_BIT;
  localparam logic [15:0] SW = 16'h0001 << wdt_pkg::RCR_SWEN_BIT;
  localparam logic [15:0] SL = 16'h0001 << wdt_pkg::RCR_SLEEP_BIT;
  localparam logic [15:0] ID = 16'h0001 << wdt_pkg::RCR_IDLE_BIT;
  logic mclk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [3:0] addr_i = 4'h0;
  logic [15:0] wdata_i = 16'h0000;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [15:0] rdata_o;
  logic [15:0] cfg_i = 16'h0000;
  logic rc_i = 1'b0;
  logic [4:0] ev_i = 5'h00;
  logic idle_i = 1'b0;
  logic low_power_rc_clock_o;
  logic rst_o;
  logic wake_o;
  logic [15:0] d;
  int n_fail = 0;
  int cmp_count = 0;
  int n_rst = 0;
  int n_wake = 0;

  always #2.5 mclk_i = ~mclk_i;

  wdt_windowed_watchdog uut (
    .mclk_i(mclk_i),
    .rstn_i(rstn_i),
    .addr_i(addr_i),
    .wdata_i(wdata_i),
    .wr_i(wr_i),
    .rd_i(rd_i),
    .rdata_o(rdata_o),
    .watchdog_config_word_i(cfg_i),
    .low_power_rc_clock_i(rc_i),
    .watchdog_clear_instruction_i(ev_i[0]),
    .clock_switch_done_i(ev_i[1]),
    .power_save_instruction_i(ev_i[2]),
    .wake_event_i(ev_i[3]),
    .device_reset_i(ev_i[4]),
    .power_save_idle_i(idle_i),
    .low_power_rc_clock_enable_o(low_power_rc_clock_o),
    .wdt_reset_o(rst_o),
    .wdt_wake_o(wake_o)
  );

  // Pulses last one cycle, so count them at every edge
  always @(posedge mclk_i) begin
    if (rst_o === 1'b1) n_rst++;
    if (wake_o === 1'b1) n_wake++;
  end

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge mclk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= v;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a);
    @(posedge mclk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1;
    d = rdata_o;
  endtask

  // 0 clear, 1 clock switch, 2 power save, 3 wake, 4 device reset
  task automatic ev(input int k);
    @(posedge mclk_i);
    ev_i <= 5'h01 << k;
    @(posedge mclk_i);
    ev_i <= 5'h00;
  endtask

  // Slow enough that each RC edge clears the synchroniser before the next
  task automatic edges(input int n);
    repeat (n) begin
      @(posedge mclk_i);
      rc_i <= 1'b1;
      repeat (4) @(posedge mclk_i);
      rc_i <= 1'b0;
      repeat (4) @(posedge mclk_i);
    end
  endtask

  task automatic setup(input logic [15:0] v);
    @(posedge mclk_i);
    cfg_i <= v;
    repeat (2) @(posedge mclk_i);
    ev(4);
    wr(wdt_pkg::RCR_ADDR, 16'h0000);
  endtask

  task automatic expect_at(input int n, input bit w);
    n_rst = 0;
    n_wake = 0;
    edges(n - 1);
    chk(16'(n_rst + n_wake), 16'h0000);
    edges(1);
    chk(16'(n_rst), w ? 16'h0000 : 16'h0001);
    chk(16'(n_wake), {15'h0000, w});
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    rd(wdt_pkg::RCR_ADDR);
    chk(d, 16'h0000);
    chk({15'h0000, low_power_rc_clock_o}, 16'h0000);
    rd(4'hf);
    chk(d, 16'h0000);
    wr(wdt_pkg::CNT_ADDR, 16'hffff);
    rd(wdt_pkg::CNT_ADDR);
    chk(d, 16'h0000);
  endtask

  task automatic t_swen();
    wr(wdt_pkg::RCR_ADDR, SW);
    @(negedge mclk_i);
    chk({15'h0000, low_power_rc_clock_o}, 16'h0001);
    rd(wdt_pkg::RCR_ADDR);
    chk(d, SW);
    ev(4);
    @(negedge mclk_i);
    chk({15'h0000, low_power_rc_clock_o}, 16'h0000);
    rd(wdt_pkg::RCR_ADDR);
    chk(d, 16'h0000);
  endtask

  task automatic t_run(input logic [15:0] v, input int n);
    setup(v);
    @(negedge mclk_i);
    chk({15'h0000, low_power_rc_clock_o}, 16'h0001);
    rd(wdt_pkg::CFG_ADDR);
    chk(d, v);
    expect_at(n, 1'b0);
    rd(wdt_pkg::RCR_ADDR);
    chk(d, TO);
    ev(4);
    rd(wdt_pkg::RCR_ADDR);
    chk(d, TO);
    wr(wdt_pkg::RCR_ADDR, 16'h0000);
    rd(wdt_pkg::RCR_ADDR);
    chk(d, 16'h0000);
  endtask

  task automatic t_restart(input int k);
    setup(16'hc080);
    edges(20);
    ev(k);
    expect_at(32, 1'b0);
  endtask

  task automatic t_sleep(input bit idle);
    logic [15:0] f;
    f = idle ? ID : SL;
    setup(16'hc080);
    edges(20);
    idle_i <= idle;
    ev(2);
    rd(wdt_pkg::RCR_ADDR);
    chk(d, f);
    rd(wdt_pkg::MODE_ADDR);
    chk(d, 16'(idle ? wdt_pkg::WDT_IDLE : wdt_pkg::WDT_SLEEP));
    expect_at(32, 1'b1);
    rd(wdt_pkg::MODE_ADDR);
    chk(d, 16'(wdt_pkg::WDT_RUN));
    rd(wdt_pkg::RCR_ADDR);
    chk(d, f | TO);
    wr(wdt_pkg::RCR_ADDR, 16'h0000);
    ev(2);
    edges(20);
    ev(2);
    rd(wdt_pkg::MODE_ADDR);
    chk(d, 16'(idle ? wdt_pkg::WDT_IDLE : wdt_pkg::WDT_SLEEP));
    ev(3);
    expect_at(32, 1'b0);
  endtask

  // Same count of 2 ticks: allowed for one window code, too early for another
  task automatic t_window(input logic [15:0] v, input bit viol);
    setup(v);
    edges(64);
    rd(wdt_pkg::CNT_ADDR);
    chk(d, 16'h0002);
    n_rst = 0;
    ev(0);
    repeat (3) @(posedge mclk_i);
    chk(16'(n_rst), {15'h0000, viol});
    if (!viol) begin
      expect_at(128, 1'b0);
    end
  endtask

  initial begin
    #100000;
    n_fail++;
    end_sim();
  end

  initial begin
    repeat (3) @(posedge mclk_i);
    rstn_i <= 1'b1;
    t_reset();
    t_swen();
    t_run(16'hc080, 32);
    t_run(16'hc090, 128);
    t_run(16'hc081, 64);
    t_restart(0);
    t_restart(1);
    t_sleep(1'b0);
    t_sleep(1'b1);
    t_window(16'hc042, 1'b0);
    t_window(16'hc002, 1'b1);
    t_window(16'hc062, 1'b0);
    t_window(16'hc022, 1'b1);
    end_sim();
  end
endmodule
